// ==== rtl/ccn_consts.svh ====
// Constants of the crate controller internal station command block.
// Assumes a single 10 MHz clock; included by the top only.
//
// Behaviour
// R1 - Two read-only 32-bit scaler latches sit at subaddresses 0xB and 0xC.
// R2 - Latch live scalers at trigger (acquisition) or stack start (interactive).
// R3 - 24-bit Lam_trigger_mask at 0x9 triggers readout when masked LAMs present.
// R4 - A zero Lam_trigger_mask makes the NIM trigger input start readout instead.
// R5 - The Lam_trigger_mask affects only acquisition triggering, nothing else.
// R6 - Default packet-end closes on 8 kByte buffer done or event end.
// R7 - Bulk setup at 0xE: buffer count bits 0-7, timeout bits 8-11.
// R8 - Watchdog closes transfer after one plus timeout seconds if unfilled.
// R9 - Host keeps the watchdog shorter than its own bulk-read timeout.
// R10 - Station 27 map write: low nibble in A, high nibble F0-3, F4 set.
// R11 - Map writes fill successive bytes; any other command zeroes the counter.
// R12 - Station 25 A15 F0 reads back a copy of the station map.
// R13 - 28/8/29 gives Z, 28/9/29 gives C, 29/9 F24 sets, F26 clears inhibit.
// R14 - Station 26 commands act on every module set in the station map.
// R15 - Station 0 A0 F16 inserts the marker word into the output stream.
// R16 - The marker flag bit selects a 32-bit marker instead of 16-bit.
// R17 - No end-of-event word is ever appended on its own.
// R18 - Station 0 F0 sets A0-2 times 100 ns pause between repeat iterations.
// R19 - A pending repeat delay is dropped once its repeat completes.
// R20 - Each delay instruction is a dummy taking one command slot of time.
// R21 - The command stack holds 1k 16-bit words.
// R22 - Stack entries carry NAF operations with optional data word.
// R23 - Station 25 F0 reads, F16 writes the register given by A.
// R24 - Map and mask bit n stand for station n+1; unused bits read zero.
// R25 - The watchdog restarts on each close and counts whole seconds.
`ifndef CCN_CONSTS_SVH
`define CCN_CONSTS_SVH

// Internal stations.
`define CCN_N_DELAY     5'd0
`define CCN_N_REGS      5'd25
`define CCN_N_BCAST     5'd26
`define CCN_N_MAPLOAD   5'd27
`define CCN_N_ZC        5'd28
`define CCN_N_INHIBIT   5'd29
`define CCN_N_LAST_SLOT 5'd24

// Functions and subaddresses.
`define CCN_F_READ      5'd0
`define CCN_F_WRITE     5'd16
`define CCN_F_ZC        5'd29
`define CCN_F_INH_SET   5'd24
`define CCN_F_INH_CLR   5'd26
`define CCN_A_Z         4'h8
`define CCN_A_C         4'h9
`define CCN_A_INHIBIT   4'h9
`define CCN_A_MARKER    4'h0

// Register subaddresses.
`define CCN_REG_LAM_TRIGGER_MASK 4'h9
`define CCN_REG_SCALER_A 4'hb
`define CCN_REG_SCALER_B 4'hc
`define CCN_REG_BULK     4'he
`define CCN_REG_MAP_COPY 4'hf

// Bulk setup fields and reset values.
`define CCN_BULK_NBUF_LSB 0
`define CCN_BULK_NBUF_MSB 7
`define CCN_BULK_TO_LSB   8
`define CCN_BULK_TO_MSB   11
`define CCN_BULK_RESET    12'h000
`define CCN_MASK_RESET    24'h000000
`define CCN_MAP_RESET     24'h000000

// Stack word layout.
`define CCN_SW_F_LSB   0
`define CCN_SW_F_MSB   4
`define CCN_SW_A_LSB   5
`define CCN_SW_A_MSB   8
`define CCN_SW_N_LSB   9
`define CCN_SW_N_MSB   13
`define CCN_SW_LONG    14
`define CCN_SW_DATA    15
`define CCN_STACK_WORDS 1024

// Timing.
`define CCN_CLK_NS      100
`define CCN_SECOND_NS   1000000000
`define CCN_SEC_CYCLES  (`CCN_SECOND_NS / `CCN_CLK_NS)
`define CCN_DLY_UNIT_NS 100
`define CCN_DLY_UNIT_CYC (`CCN_DLY_UNIT_NS / `CCN_CLK_NS)

`endif

// ==== rtl/ccn_pkg.sv ====
// Types of the crate controller internal station command block.
// Assumes the constants header is on the include path.
package ccn_pkg;

	// ---------------------------------------------------------------
	// Command and dataway carriers
	// ---------------------------------------------------------------

	// One command as presented by the host or fetched from the stack.
	typedef struct packed {
		logic [4:0]  n;
		logic [3:0]  a;
		logic [4:0]  f;
		logic        marker_long;
		logic [7:0]  rep;
		logic [31:0] data;
	} ccn_cmd_t;

	// One dataway cycle request towards the crate.
	typedef struct packed {
		logic        strobe;
		logic        z;
		logic        c;
		logic [23:0] map;
		logic [3:0]  a;
		logic [4:0]  f;
		logic [31:0] data;
	} ccn_dw_t;

	// Gray codes along idle, fetch, data, execute, gap.
	typedef enum logic [2:0] {
		CCN_IDLE  = 3'h0,
		CCN_FETCH = 3'h1,
		CCN_DATA  = 3'h3,
		CCN_EXEC  = 3'h2,
		CCN_GAP   = 3'h6
	} ccn_state_t;

endpackage : ccn_pkg

// ==== rtl/ccn_naf_top.sv ====
// Internal station command interpreter of the crate controller.
// Assumes commands come from logic on clock_in; LAM and NIM pins are async.
`timescale 1ns/1ps
`include "ccn_consts.svh"

module ccn_naf_top
	import ccn_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `CCN_SEC_CYCLES
) (
	input  wire logic          clock_in,
	input  wire logic          rst_n_in,
	input  wire logic          ce_in,
	input  wire ccn_cmd_t      cmd_in,
	input  wire logic          cmd_valid_in,
	output logic               cmd_ready_out,
	input  wire logic          stk_we_in,
	input  wire logic [9:0]    stk_addr_in,
	input  wire logic [15:0]   stk_data_in,
	input  wire logic [9:0]    stk_len_in,
	input  wire logic          stk_run_in,
	input  wire logic          acq_mode_in,
	input  wire logic [23:0]   lam_in,
	input  wire logic          nim_trig_in,
	input  wire logic [31:0]   first_event_counter_in,
	input  wire logic [31:0]   second_event_counter_in,
	input  wire logic          buf_done_in,
	input  wire logic          evt_end_in,
	output ccn_dw_t            dw_out,
	output logic               inhibit_out,
	output logic               rd_valid_out,
	output logic [31:0]        rd_data_out,
	output logic               mk_valid_out,
	output logic               mk_long_out,
	output logic [31:0]        mk_data_out,
	output logic               pkt_end_out,
	output logic               evt_trig_out
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------

	typedef struct packed {
		ccn_state_t  st;
		ccn_cmd_t    cmd;
		logic        run;
		logic [9:0]  ptr;
		logic [7:0]  rep_left;
		logic [2:0]  gap;
		logic [2:0]  dly_pend;
		logic [23:0] lam_trigger_mask;
		logic [23:0] smap;
		logic [23:0] notepad;
		logic [1:0]  map_byte;
		logic [11:0] bulk;
		logic [31:0] scl_a;
		logic [31:0] scl_b;
		logic [23:0] lam_m;
		logic [23:0] lam_s;
		logic        nim_m;
		logic        nim_s;
		logic        cond;
		logic [31:0] wd_cyc;
		logic [4:0]  wd_sec;
		logic [7:0]  buf_cnt;
		logic        pend;
		logic        rdy;
		logic        rd_valid;
		logic [31:0] rd_data;
		ccn_dw_t     dw;
		logic        inhibit;
		logic        mk_valid;
		logic        mk_long;
		logic [31:0] mk_data;
		logic        pkt_end;
		logic        evt_trig;
	} ccn_regs_t;

	ccn_regs_t q;
	ccn_regs_t d;

	// The stack is plain storage; only the interpreter reads it.
	logic [15:0] stack_mem [0:`CCN_STACK_WORDS-1]; // R21

	// ---------------------------------------------------------------
	// Decoders
	// ---------------------------------------------------------------

	// One-hot station select; station n maps to bit n-1.
	function automatic logic [23:0] slot_bit(input logic [4:0] n);
		logic [23:0] m;
		m = 24'h000000;
		if (n != 5'h00 && n <= `CCN_N_LAST_SLOT) begin
			m[n - 5'h01] = 1'b1; // R24
		end
		return m;
	endfunction : slot_bit

	// True for a byte load of the station map.
	function automatic logic is_map_load(input ccn_cmd_t c);
		return (c.n == `CCN_N_MAPLOAD) && c.f[4]; // R10
	endfunction : is_map_load

	// Decode a stack word into a single command.
	function automatic ccn_cmd_t word_cmd(input logic [15:0] w);
		ccn_cmd_t c;
		c             = '0;
		c.f           = w[`CCN_SW_F_MSB:`CCN_SW_F_LSB];
		c.a           = w[`CCN_SW_A_MSB:`CCN_SW_A_LSB];
		c.n           = w[`CCN_SW_N_MSB:`CCN_SW_N_LSB];
		c.marker_long = w[`CCN_SW_LONG];
		c.rep         = 8'h01;
		return c;
	endfunction : word_cmd

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------

	logic        trig_cond;
	logic        more;
	logic [7:0]  nbuf;
	logic [4:0]  limit_sec;
	logic        close;
	logic        sec_tick;

	// Everything is computed from q and the inputs; pulses default low each cycle.
	always_comb begin
		d             = q;
		d.rd_valid    = 1'b0;
		d.dw.strobe   = 1'b0;
		d.dw.z        = 1'b0;
		d.dw.c        = 1'b0;
		d.mk_valid    = 1'b0;
		d.pkt_end     = 1'b0;
		d.evt_trig    = 1'b0;
		more          = 1'b0;

		// Two-stage synchronisers for the pin inputs.
		d.lam_m = lam_in;
		d.lam_s = q.lam_m;
		d.nim_m = nim_trig_in;
		d.nim_s = q.nim_m;

		// Trigger on the rising edge of the condition, acquisition only.
		// The mask never touches the raw LAM view kept elsewhere.
		if (q.lam_trigger_mask != 24'h000000) begin
			trig_cond = ((q.lam_s & q.lam_trigger_mask) == q.lam_trigger_mask); // R3 R5
		end else begin
			trig_cond = q.nim_s; // R4
		end
		d.cond = trig_cond;
		if (acq_mode_in && trig_cond && !q.cond) begin
			d.evt_trig = 1'b1;
			d.scl_a    = first_event_counter_in; // R2
			d.scl_b    = second_event_counter_in; // R2
		end

		// Interpreter sequence.
		case (q.st)
		CCN_IDLE: begin
			if (q.rdy && cmd_valid_in) begin
				d.cmd      = cmd_in;
				d.rep_left = (cmd_in.rep == 8'h00) ? 8'h01 : cmd_in.rep;
				d.st       = CCN_EXEC;
			end else if (q.rdy && stk_run_in && stk_len_in != 10'h000) begin
				d.run = 1'b1;
				d.ptr = 10'h000;
				d.st  = CCN_FETCH;
				if (!acq_mode_in) begin
					d.scl_a = first_event_counter_in; // R2
					d.scl_b = second_event_counter_in; // R2
				end
			end
		end
		CCN_FETCH: begin
			d.cmd      = word_cmd(stack_mem[q.ptr]); // R22
			d.rep_left = 8'h01;
			d.ptr      = q.ptr + 10'h001;
			d.st       = stack_mem[q.ptr][`CCN_SW_DATA] ? CCN_DATA : CCN_EXEC;
		end
		CCN_DATA: begin
			d.cmd.data = {16'h0000, stack_mem[q.ptr]}; // R22
			d.ptr      = q.ptr + 10'h001;
			d.st       = CCN_EXEC;
		end
		CCN_EXEC: begin
			// Byte counter of the map load; any other command restarts it.
			if (is_map_load(q.cmd)) begin
				case (q.map_byte)
				2'h0: begin
					d.smap[7:0]    = {q.cmd.f[3:0], q.cmd.a}; // R10 R11
					d.notepad[7:0] = {q.cmd.f[3:0], q.cmd.a}; // R12
				end
				2'h1: begin
					d.smap[15:8]    = {q.cmd.f[3:0], q.cmd.a}; // R11
					d.notepad[15:8] = {q.cmd.f[3:0], q.cmd.a};
				end
				default: begin
					d.smap[23:16]    = {q.cmd.f[3:0], q.cmd.a}; // R11
					d.notepad[23:16] = {q.cmd.f[3:0], q.cmd.a};
				end
				endcase
				d.map_byte = (q.map_byte >= 2'h2) ? 2'h0 : q.map_byte + 2'h1;
			end else begin
				d.map_byte = 2'h0; // R11
			end

			case (q.cmd.n)
			`CCN_N_DELAY: begin
				// A delay word is a dummy that still uses this cycle.
				if (q.cmd.f == `CCN_F_READ) begin
					d.dly_pend = q.cmd.a[2:0]; // R18 R20
				end else if (q.cmd.f == `CCN_F_WRITE
				             && q.cmd.a == `CCN_A_MARKER) begin
					d.mk_valid = 1'b1; // R15 R17
					d.mk_long  = q.cmd.marker_long; // R16
					d.mk_data  = q.cmd.marker_long ? q.cmd.data
					             : {16'h0000, q.cmd.data[15:0]}; // R16
				end
			end
			`CCN_N_REGS: begin
				if (q.cmd.f == `CCN_F_READ) begin
					d.rd_valid = 1'b1; // R23
					case (q.cmd.a)
					`CCN_REG_LAM_TRIGGER_MASK: d.rd_data = {8'h00, q.lam_trigger_mask};
					`CCN_REG_SCALER_A: d.rd_data = q.scl_a; // R1
					`CCN_REG_SCALER_B: d.rd_data = q.scl_b; // R1
					`CCN_REG_BULK:     d.rd_data = {20'h00000, q.bulk};
					`CCN_REG_MAP_COPY: d.rd_data = {8'h00, q.notepad}; // R12
					default:           d.rd_data = 32'h00000000;
					endcase
				end else if (q.cmd.f == `CCN_F_WRITE) begin
					if (q.cmd.a == `CCN_REG_LAM_TRIGGER_MASK) begin
						d.lam_trigger_mask = q.cmd.data[23:0]; // R3 R23
					end
					if (q.cmd.a == `CCN_REG_BULK) begin
						d.bulk = q.cmd.data[11:0]; // R7
					end
				end
			end
			`CCN_N_BCAST: begin
				d.dw.strobe = 1'b1;
				d.dw.map    = q.smap; // R14
				d.dw.a      = q.cmd.a;
				d.dw.f      = q.cmd.f;
				d.dw.data   = q.cmd.data;
			end
			`CCN_N_ZC: begin
				if (q.cmd.f == `CCN_F_ZC && q.cmd.a == `CCN_A_Z) begin
					d.dw.z = 1'b1; // R13
				end
				if (q.cmd.f == `CCN_F_ZC && q.cmd.a == `CCN_A_C) begin
					d.dw.c = 1'b1; // R13
				end
			end
			`CCN_N_INHIBIT: begin
				if (q.cmd.a == `CCN_A_INHIBIT
				    && q.cmd.f == `CCN_F_INH_SET) begin
					d.inhibit = 1'b1; // R13
				end
				if (q.cmd.a == `CCN_A_INHIBIT
				    && q.cmd.f == `CCN_F_INH_CLR) begin
					d.inhibit = 1'b0; // R13
				end
			end
			default: begin
				if (slot_bit(q.cmd.n) != 24'h000000) begin
					d.dw.strobe = 1'b1;
					d.dw.map    = slot_bit(q.cmd.n);
					d.dw.a      = q.cmd.a;
					d.dw.f      = q.cmd.f;
					d.dw.data   = q.cmd.data;
				end
			end
			endcase

			// Repeat iterations, with the pending pause between them.
			more       = (q.rep_left > 8'h01);
			d.rep_left = q.rep_left - 8'h01;
			if (more) begin
				if (q.dly_pend != 3'h0) begin
					d.gap = q.dly_pend; // R18
					d.st  = CCN_GAP;
				end
			end else begin
				if (q.cmd.rep > 8'h01) begin
					d.dly_pend = 3'h0; // R19
				end
				if (q.run && q.ptr < stk_len_in) begin
					d.st = CCN_FETCH;
				end else begin
					d.run = 1'b0;
					d.st  = CCN_IDLE;
				end
			end
		end
		CCN_GAP: begin
			// One count per delay unit of one clock.
			d.gap = q.gap - 3'h1;
			if (q.gap == 3'h1) begin
				d.st = CCN_EXEC; // R18
			end
		end
		default: begin
			d.st  = CCN_IDLE;
			d.run = 1'b0;
		end
		endcase
		d.rdy = (d.st == CCN_IDLE);

		// Bulk bundling and its watchdog.
		nbuf      = q.bulk[`CCN_BULK_NBUF_MSB:`CCN_BULK_NBUF_LSB];
		limit_sec = {1'b0, q.bulk[`CCN_BULK_TO_MSB:`CCN_BULK_TO_LSB]}
		            + 5'h01; // R8
		sec_tick  = (q.wd_cyc == SEC_CYCLES - 1);
		close     = 1'b0;
		if (nbuf == 8'h00) begin
			close = buf_done_in || evt_end_in; // R6
		end else begin
			if (buf_done_in && (q.buf_cnt + 8'h01 >= nbuf)) begin
				close = 1'b1; // R7
			end
			if (q.pend && sec_tick && (q.wd_sec + 5'h01 >= limit_sec)) begin
				close = 1'b1; // R8
			end
		end
		if (close) begin
			// A closed transfer restarts the count from zero.
			d.pkt_end = 1'b1;
			d.buf_cnt = 8'h00;
			d.pend    = 1'b0;
			d.wd_cyc  = 32'h00000000; // R25
			d.wd_sec  = 5'h00; // R25
		end else begin
			if (buf_done_in) begin
				d.buf_cnt = q.buf_cnt + 8'h01;
			end
			// Data waiting sets pending; a close in the same cycle clears it instead.
			d.pend = q.pend || buf_done_in || evt_end_in;
			if (q.pend) begin
				d.wd_cyc = sec_tick ? 32'h00000000 : q.wd_cyc + 32'h00000001;
				if (sec_tick) begin
					d.wd_sec = q.wd_sec + 5'h01; // R25
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------

	// Synchronous reset; the clock enable freezes all state.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			q          <= '0;
			q.st       <= CCN_IDLE;
			q.rdy      <= 1'b1;
			q.lam_trigger_mask <= `CCN_MASK_RESET;
			q.smap     <= `CCN_MAP_RESET;
			q.notepad  <= `CCN_MAP_RESET;
			q.bulk     <= `CCN_BULK_RESET;
		end else if (ce_in) begin
			q <= d;
		end
	end

	// Stack loading; words written while running take effect on fetch.
	always_ff @(posedge clock_in) begin
		if (ce_in && stk_we_in) begin
			stack_mem[stk_addr_in] <= stk_data_in; // R21
		end
	end

	// Outputs straight from the state register.
	assign cmd_ready_out = q.rdy;
	assign dw_out        = q.dw;
	assign inhibit_out   = q.inhibit;
	assign rd_valid_out  = q.rd_valid;
	assign rd_data_out   = q.rd_data;
	assign mk_valid_out  = q.mk_valid;
	assign mk_long_out   = q.mk_long;
	assign mk_data_out   = q.mk_data;
	assign pkt_end_out   = q.pkt_end;
	assign evt_trig_out  = q.evt_trig;

endmodule : ccn_naf_top

// ==== tb/ccn_naf_checker.sv ====
// Checker of the internal station command interpreter.
// Assumes it is bound to ccn_naf_top and sees only its ports.
`timescale 1ns/1ps
module ccn_naf_checker
	import ccn_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        rst_n_in,
	input wire logic        ce_in,
	input wire ccn_cmd_t    cmd_in,
	input wire logic        cmd_valid_in,
	input wire logic        cmd_ready_out,
	input wire ccn_dw_t     dw_out,
	input wire logic        inhibit_out,
	input wire logic        rd_valid_out,
	input wire logic        mk_valid_out,
	input wire logic        mk_long_out,
	input wire logic [31:0] mk_data_out,
	input wire logic        pkt_end_out,
	input wire logic        evt_trig_out
);
	// ---------------------------------------------------------------
	// Taken command decode
	// ---------------------------------------------------------------
	// Effects are tied to the edge that takes the command.
	wire logic        tk  = ce_in && cmd_valid_in && cmd_ready_out;
	wire logic [13:0] naf = {cmd_in.n, cmd_in.a, cmd_in.f};

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	chk_z_issue: assert property (
		tk && naf == {5'h1c, 4'h8, 5'h1d} |-> ##2 dw_out.z)
		else $error("Z missing");
	chk_c_issue: assert property (
		tk && naf == {5'h1c, 4'h9, 5'h1d} |-> ##2 dw_out.c)
		else $error("C missing");
	chk_inh_set: assert property (
		tk && naf == {5'h1d, 4'h9, 5'h18} |-> ##2 inhibit_out)
		else $error("inhibit not set");
	chk_inh_clear: assert property (
		tk && naf == {5'h1d, 4'h9, 5'h1a} |-> ##2 !inhibit_out)
		else $error("inhibit not cleared");
	chk_marker_word: assert property (
		tk && naf == {5'h0, 4'h0, 5'h10} |-> ##2 mk_valid_out &&
		mk_long_out == $past(cmd_in.marker_long, 2) &&
		mk_data_out == ($past(cmd_in.marker_long, 2) ? $past(cmd_in.data, 2)
		: {16'h0, $past(cmd_in.data[15:0], 2)}))
		else $error("marker wrong");
	chk_delay_slot: assert property (
		tk && cmd_in.n == 5'h0 && cmd_in.f == 5'h0 |=> !cmd_ready_out
		##1 (cmd_ready_out && !dw_out.strobe))
		else $error("delay slot wrong");
	chk_read_answer: assert property (
		tk && cmd_in.n == 5'h19 && cmd_in.f == 5'h0 |-> ##2 rd_valid_out)
		else $error("read not answered");
	chk_bcast_fields: assert property (
		tk && cmd_in.n == 5'h1a |-> ##2 dw_out.strobe &&
		dw_out.a == $past(cmd_in.a, 2) && dw_out.f == $past(cmd_in.f, 2))
		else $error("broadcast fields wrong");
	chk_slot_onehot: assert property (
		tk && cmd_in.n inside {[5'h1:5'h18]} |-> ##2 dw_out.strobe &&
		dw_out.map == (24'h1 << ($past(cmd_in.n, 2) - 5'h1)))
		else $error("station map wrong");

	// Main scenarios seen at least once.
	cover property (pkt_end_out);
	cover property (evt_trig_out);
	cover property (mk_valid_out && mk_long_out);
endmodule : ccn_naf_checker

bind ccn_naf_top ccn_naf_checker ccn_naf_checker_inst (.clock_in,
	.rst_n_in, .ce_in, .cmd_in, .cmd_valid_in, .cmd_ready_out, .dw_out,
	.inhibit_out, .rd_valid_out, .mk_valid_out, .mk_long_out,
	.mk_data_out, .pkt_end_out, .evt_trig_out);

// ==== tb/ccn_crate_model.sv ====
// Behavioural crate of dataway modules facing the interpreter.
// Assumes the bench asks for LAMs; dataway cycles come from the design.
`timescale 1ns/1ps
module ccn_crate_model
	import ccn_pkg::*;
(
	input  wire ccn_dw_t     dw_in,
	input  wire logic        clock_in,
	input  wire logic [23:0] lam_req_in,
	output logic [23:0]      lam_out,
	output logic [23:0]      hit_map_out,
	output int               strobe_cnt_out,
	output int               z_cnt_out,
	output int               c_cnt_out
);
	// Nothing is selected and no LAM is up before the first cycle.
	initial begin
		{lam_out, hit_map_out} = '0;
		{strobe_cnt_out, z_cnt_out, c_cnt_out} = '0;
	end

	// Selected modules take each cycle; Z and C drop every LAM for a cycle.
	always @(posedge clock_in) begin
		if (dw_in.strobe) begin
			strobe_cnt_out <= strobe_cnt_out + 1;
			hit_map_out    <= dw_in.map;
		end
		z_cnt_out <= z_cnt_out + int'(dw_in.z);
		c_cnt_out <= c_cnt_out + int'(dw_in.c);
		lam_out   <= (dw_in.z || dw_in.c) ? 24'h0 : lam_req_in;
	end
endmodule : ccn_crate_model

// ==== tb/ccn_naf_top_tb_top.sv ====
// Self-checking bench of the internal station command interpreter.
// Assumes design, package, crate model and checker are compiled first.
`timescale 1ns/1ps
module ccn_naf_top_tb_top
	import ccn_pkg::*;
;
	localparam int SEC = 20; // A short second keeps the watchdog test fast.
	logic        clock_in, rst_n_in, cmd_valid_in, stk_we_in, stk_run_in;
	logic        acq_mode_in, nim_trig_in, buf_done_in, evt_end_in, ce;
	logic        cmd_ready_out, inhibit_out, rd_valid_out, mk_valid_out;
	logic        mk_long_out, pkt_end_out, evt_trig_out, got_ml;
	logic [9:0]  stk_addr_in, stk_len_in;
	logic [15:0] stk_data_in;
	logic [23:0] lam, lam_req, hit_map;
	logic [31:0] cnt_a, cnt_b, rd_data_out, mk_data_out, got_rd, got_mk;
	ccn_cmd_t    cmd_in;
	ccn_dw_t     dw_out;
	int          num_errors, comparisons, cyc, n_mk, n_pkt, n_trig, gap;
	int          last_t, n_strb, n_z, n_c, k, i;

	always #50 clock_in = ~clock_in;

	ccn_naf_top #(.SEC_CYCLES(SEC)) ccn_naf_top_inst (.clock_in, .rst_n_in,
		.ce_in(ce), .cmd_in, .cmd_valid_in, .cmd_ready_out, .stk_we_in,
		.stk_addr_in, .stk_data_in, .stk_len_in, .stk_run_in, .acq_mode_in,
		.lam_in(lam), .nim_trig_in, .first_event_counter_in(cnt_a),
		.second_event_counter_in(cnt_b), .buf_done_in, .evt_end_in, .dw_out,
		.inhibit_out, .rd_valid_out, .rd_data_out, .mk_valid_out,
		.mk_long_out, .mk_data_out, .pkt_end_out, .evt_trig_out);

	ccn_crate_model ccn_crate_model_inst (.dw_in(dw_out), .clock_in,
		.lam_req_in(lam_req), .lam_out(lam), .hit_map_out(hit_map),
		.strobe_cnt_out(n_strb), .z_cnt_out(n_z), .c_cnt_out(n_c));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, exp, input string w);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk

	// Holds the request until taken, then waits out the whole command.
	task automatic cmd(input logic [4:0] n, input logic [3:0] a,
		input logic [4:0] f, input logic [31:0] d = 32'h0,
		input logic ml = 1'b0, input logic [7:0] rep = 8'h1);
		@(posedge clock_in);
		cmd_valid_in <= 1'b1;
		cmd_in       <= '{n, a, f, ml, rep, d};
		do @(posedge clock_in); while (cmd_ready_out !== 1'b1);
		cmd_valid_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		while (cmd_ready_out !== 1'b1) @(posedge clock_in);
		@(negedge clock_in);
	endtask : cmd

	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input string w);
		got_rd = 'x;
		cmd(5'h19, a, 5'h0);
		chk(got_rd, e, w);
	endtask : rd

	task automatic mb(input logic [7:0] b);
		cmd(5'h1b, b[3:0], {1'b1, b[7:4]});
	endtask : mb

	task automatic pb(input logic ev);
		@(posedge clock_in);
		evt_end_in  <= ev;
		buf_done_in <= !ev;
		@(posedge clock_in);
		{evt_end_in, buf_done_in} <= 2'h0;
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
	endtask : pb

	// Tally answer pulses; a hang is cut off well past the expected run.
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			$display("[ERR] %0t run hung", $time);
			give_verdict();
		end
		if (rd_valid_out) got_rd = rd_data_out;
		if (mk_valid_out) begin
			n_mk++;
			got_mk = mk_data_out;
			got_ml = mk_long_out;
		end
		if (dw_out.strobe) begin
			gap    = cyc - last_t;
			last_t = cyc;
		end
		n_pkt  += int'(pkt_end_out);
		n_trig += int'(evt_trig_out);
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{clock_in, rst_n_in, cmd_valid_in, stk_we_in, stk_run_in} = '0;
		{acq_mode_in, nim_trig_in, buf_done_in, evt_end_in, got_ml} = '0;
		{stk_addr_in, stk_len_in, stk_data_in, lam_req, cnt_a, cnt_b} = '0;
		{got_rd, got_mk, cmd_in} = '0;
		ce = 1'b1;
		{num_errors, comparisons, cyc, n_mk, n_pkt, n_trig, gap, last_t} = '0;
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd(4'h9, 32'h0, "mask reset");
		rd(4'he, 32'h0, "bulk reset");
		cmd(5'h19, 4'h9, 5'h10, 32'hffffffff);
		rd(4'h9, 32'h00ffffff, "mask width");
		cmd(5'h19, 4'he, 5'h10, 32'hffffffff);
		rd(4'he, 32'h00000fff, "bulk fields");
		rd(4'h3, 32'h0, "unmapped");
		$display("test registers done");
		mb(8'h5a);
		mb(8'h3c);
		mb(8'h81);
		rd(4'hf, 32'h00813c5a, "map load");
		mb(8'h11);
		rd(4'hf, 32'h00813c11, "map wrap");
		mb(8'h22);
		rd(4'hf, 32'h00813c22, "map restart");
		cmd(5'h1a, 4'h3, 5'h10, 32'h1234);
		chk(hit_map, 32'h00813c22, "broadcast map");
		cmd(5'h5, 4'h1, 5'h10);
		chk(hit_map, 32'h00000010, "station map");
		$display("test station map done");
		cmd(5'h1c, 4'h8, 5'h1d);
		cmd(5'h1c, 4'h9, 5'h1d);
		chk(n_z, 32'h1, "Z count");
		chk(n_c, 32'h1, "C count");
		cmd(5'h1d, 4'h9, 5'h18);
		chk(inhibit_out, 32'h1, "inhibit set");
		cmd(5'h1d, 4'h9, 5'h1a);
		chk(inhibit_out, 32'h0, "inhibit clear");
		cmd(5'h0, 4'h0, 5'h10, 32'hdeadbeef);
		chk(got_mk, 32'h0000beef, "short marker");
		cmd(5'h0, 4'h0, 5'h10, 32'hdeadbeef, 1'b1);
		chk({got_ml, got_mk[30:0]}, 32'hdeadbeef, "long marker");
		pb(1'b1);
		chk(n_mk, 32'h2, "marker count");
		// A command offered while the enable is low must not be taken.
		@(posedge clock_in);
		ce <= 1'b0;
		cmd(5'h1d, 4'h9, 5'h18);
		chk(inhibit_out, 32'h0, "clock enable freeze");
		@(posedge clock_in);
		ce <= 1'b1;
		$display("test controller functions done");
		k = n_strb;
		cmd(5'h0, 4'h5, 5'h0);
		chk(n_strb, k, "delay no cycle");
		cmd(5'h3, 4'h0, 5'h10, 32'h0, 1'b0, 8'h3);
		chk(gap, 32'h6, "repeat gap");
		chk(n_strb, k + 3, "repeat count");
		cmd(5'h3, 4'h0, 5'h10, 32'h0, 1'b0, 8'h3);
		chk(gap, 32'h1, "delay dropped");
		$display("test repeat done");
		cmd(5'h19, 4'he, 5'h10, 32'h0);
		k = n_pkt;
		pb(1'b1);
		chk(n_pkt, k + 1, "close on event end");
		pb(1'b0);
		chk(n_pkt, k + 2, "close on buffer");
		cmd(5'h19, 4'he, 5'h10, 32'h00000102);
		pb(1'b0);
		k = cyc;
		i = n_pkt;
		// The bench's own read limit stays well above the watchdog time.
		while (n_pkt == i && cyc - k < 100) @(negedge clock_in);
		chk(32'((cyc - k) inside {[34:42]}), 32'h1, "watchdog");
		k = n_pkt;
		pb(1'b0);
		pb(1'b0);
		chk(n_pkt, k + 1, "bundle count");
		$display("test bundling done");
		cmd(5'h19, 4'h9, 5'h10, 32'h0);
		k = n_trig;
		@(posedge clock_in);
		acq_mode_in <= 1'b1;
		cnt_a       <= 32'h11111111;
		nim_trig_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		cnt_a <= 32'h99999999;
		@(negedge clock_in);
		chk(n_trig, k + 1, "nim trigger");
		rd(4'hb, 32'h11111111, "trigger latch");
		cmd(5'h19, 4'h9, 5'h10, 32'h5);
		@(posedge clock_in);
		lam_req <= 24'h1;
		repeat (8) @(posedge clock_in);
		lam_req <= 24'h5;
		@(negedge clock_in);
		chk(n_trig, k + 1, "partial lam");
		repeat (8) @(negedge clock_in);
		chk(n_trig, k + 2, "masked lam");
		@(posedge clock_in);
		{acq_mode_in, lam_req} <= '0;
		cnt_b       <= 32'h33333333;
		stk_we_in   <= 1'b1;
		stk_addr_in <= 10'h1;
		stk_data_in <= 16'h8010;
		stk_len_in  <= 10'h3;
		@(posedge clock_in);
		stk_addr_in <= 10'h2;
		stk_data_in <= 16'h1234;
		@(posedge clock_in);
		stk_addr_in <= 10'h0;
		stk_data_in <= 16'h3380;
		@(posedge clock_in);
		stk_we_in  <= 1'b0;
		stk_run_in <= 1'b1;
		@(posedge clock_in);
		stk_run_in <= 1'b0;
		cnt_b      <= 32'h44444444;
		repeat (8) @(posedge clock_in);
		rd(4'hc, 32'h33333333, "stack latch");
		chk(got_mk, 32'h00001234, "stack data word");
		cmd(5'h19, 4'hc, 5'h10, 32'h0);
		rd(4'hc, 32'h33333333, "scaler read only");
		$display("test triggers done");
		give_verdict();
	end
endmodule : ccn_naf_top_tb_top
